// ==== design/dtc_timer.sv ====
/*
  Dual timer/counter with control flags, reload registers and interrupt status.
  Assumes a plain register port; pins are asynchronous and synchronised here.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module dtc_timer
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire dtc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Pins
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  // Interrupt vectoring acknowledges
  input wire logic t0_vec_ack,
  input wire logic t1_vec_ack,
  input wire logic x0_vec_ack,
  input wire logic x1_vec_ack,
  // Flags and events
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic ext_ext_pin_a_edge_flag,
  output logic ext_int1_edge_flag,
  output logic baud_tick,
  output logic irq
);

  initial begin
    if (ADDR_W < 11) $error("Address too narrow for register map");
  end

  logic [7:0] timer_control_flags;
  logic [7:0] timer_mode_select_reg;
  logic [7:0] timer_toggle_status_reg;
  logic [7:0] presc_r, istat_r, imask_r, rd_data_r;
  logic [7:0] count_low_byte [2];
  logic [7:0] count_high_byte [2];
  logic [7:0] low_reload_holding [2];
  logic [7:0] high_reload_holding [2];
  logic [7:0] lo_nxt [2];
  logic [7:0] hi_nxt [2];
  logic [1:0] ovf_lo;
  logic ovf_split_hi;
  logic t0_split;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic samp_r;
  logic [1:0] cpin_q_r, cfall, xprev_r, xset;
  logic [5:0] div_r, div_lim;
  logic prescaled_timer_tick;
  logic t0_set, t1_set;
  logic [3:0] ev;

  wire wr = bus_req.wr;
  wire rd = bus_req.rd;
  wire [ADDR_W-1:0] addr = bus_req.addr;

  // ----------------------------------------
  // Pin synchronisers and sampling
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
    end else begin
      pin_s1_r <= {ext_pin_b, ext_pin_a, t1_count_pin, t0_count_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      samp_r <= 1'b0;
      cpin_q_r <= 2'h3;
    end else begin
      samp_r <= ~samp_r;
      if (samp_r) cpin_q_r <= pin_s2_r[1:0];
    end
  end
  assign cfall = {2{samp_r}} & cpin_q_r & ~pin_s2_r[1:0];

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Selectable tick divide
  always_comb begin
    unique case (presc_r[1:0])
      2'h0: div_lim = DIV_LIM_A;
      2'h1: div_lim = DIV_LIM_B;
      default: div_lim = DIV_LIM_C;
    endcase
  end
  assign prescaled_timer_tick = (div_r == div_lim);

  always_ff @(posedge core_clk) begin
    if (rst) div_r <= 6'h00;
    else if (prescaled_timer_tick || div_r > div_lim) div_r <= 6'h00;
    else div_r <= div_r + 6'h01;
  end

  // ----------------------------------------
  // External interrupt detection
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) xprev_r <= 2'h3;
    else xprev_r <= pin_s2_r[3:2];
  end
  assign xset[0] = timer_control_flags[CB_IT0] ? (xprev_r[0] & ~pin_s2_r[2]) : ~pin_s2_r[2];
  assign xset[1] = timer_control_flags[CB_IT1] ? (xprev_r[1] & ~pin_s2_r[3]) : ~pin_s2_r[3];

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  assign t0_split = (timer_mode_select_reg[1:0] == MODE_SPLIT);

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    localparam int RUN_BIT = (i == 0) ? CB_TR0 : CB_TR1;
    localparam logic [11:0] A_LO = OFS_T0_LO + 12'(OFS_STRIDE * i);
    localparam logic [11:0] A_RL = OFS_RL0_LO + 12'(OFS_STRIDE * i);
    dtc_timer_mode_select_reg_half_t cfg;
    dtc_mode_t md;
    logic gate_ok, src, adv, hi_adv, oh;
    assign cfg = timer_mode_select_reg[MODE_HALF_W*i +: MODE_HALF_W];
    assign md = dtc_mode_t'(cfg.mode);
    assign gate_ok = ~cfg.gate | pin_s2_r[2+i];
    assign src = cfg.count_sel ? cfall[i] : prescaled_timer_tick;
    if (i == 0) begin : g_t0
      assign adv = timer_control_flags[RUN_BIT] & gate_ok & src;
      assign hi_adv = timer_control_flags[CB_TR1] & prescaled_timer_tick;
    end else begin : g_t1
      // Mode 3 holds, else runs on TR1 or timer 0 split
      assign adv = (timer_control_flags[RUN_BIT] | t0_split) & gate_ok & src
                   & (md != MODE_SPLIT);
      assign hi_adv = 1'b0;
    end

    always_comb begin
      lo_nxt[i] = count_low_byte[i];
      hi_nxt[i] = count_high_byte[i];
      ovf_lo[i] = 1'b0;
      oh = 1'b0;
      unique case (md)
        MODE_RELOAD16: if (adv) begin
          if ({count_high_byte[i], count_low_byte[i]} == {BYTE_MAX, BYTE_MAX}) begin
            ovf_lo[i] = 1'b1;
            lo_nxt[i] = low_reload_holding[i];
            hi_nxt[i] = high_reload_holding[i];
          end else begin
            {hi_nxt[i], lo_nxt[i]} = {count_high_byte[i], count_low_byte[i]} + 16'h0001;
          end
        end
        MODE_FREE16: if (adv) begin
          ovf_lo[i] = ({count_high_byte[i], count_low_byte[i]} == {BYTE_MAX, BYTE_MAX});
          {hi_nxt[i], lo_nxt[i]} = {count_high_byte[i], count_low_byte[i]} + 16'h0001;
        end
        MODE_RELOAD8: if (adv) begin
          if (count_low_byte[i] == BYTE_MAX) begin
            ovf_lo[i] = 1'b1;
            lo_nxt[i] = low_reload_holding[i];
          end else begin
            lo_nxt[i] = count_low_byte[i] + 8'h01;
          end
        end
        MODE_SPLIT: begin
          if (adv) begin
            ovf_lo[i] = (count_low_byte[i] == BYTE_MAX);
            lo_nxt[i] = count_low_byte[i] + 8'h01;
          end
          if (hi_adv) begin
            oh = (count_high_byte[i] == BYTE_MAX);
            hi_nxt[i] = count_high_byte[i] + 8'h01;
          end
        end
      endcase
      if (wr && addr == A_LO) lo_nxt[i] = bus_req.wdata;
      if (wr && addr == A_LO + 12'h001) hi_nxt[i] = bus_req.wdata;
    end

    if (i == 0) begin : g_oh
      assign ovf_split_hi = oh;
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        count_low_byte[i] <= RST_BYTE;
        count_high_byte[i] <= RST_BYTE;
      end else begin
        count_low_byte[i] <= lo_nxt[i];
        count_high_byte[i] <= hi_nxt[i];
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        low_reload_holding[i] <= RST_BYTE;
        high_reload_holding[i] <= RST_BYTE;
      end else if (wr && addr == A_RL) begin
        low_reload_holding[i] <= bus_req.wdata;
      end else if (wr && addr == A_RL + 12'h001) begin
        high_reload_holding[i] <= bus_req.wdata;
      end
    end

    reload_both_a: assert property (@(posedge core_clk) disable iff (rst)
      (md == MODE_RELOAD16 && ovf_lo[i] && !(wr && (addr == A_LO || addr == A_LO + 12'h001)))
      |=> {count_high_byte[i], count_low_byte[i]}
          == {$past(high_reload_holding[i]), $past(low_reload_holding[i])})
      else $error("Mode 0 reload wrong");
    high_kept_a: assert property (@(posedge core_clk) disable iff (rst)
      (md == MODE_RELOAD8 && ovf_lo[i] && !(wr && addr == A_LO + 12'h001))
      |=> count_high_byte[i] == $past(count_high_byte[i]))
      else $error("Mode 2 disturbed high byte");
    low_reload_a: assert property (@(posedge core_clk) disable iff (rst)
      (md == MODE_RELOAD8 && ovf_lo[i] && !(wr && addr == A_LO))
      |=> count_low_byte[i] == $past(low_reload_holding[i]))
      else $error("Mode 2 low reload wrong");
    free_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
      (md == MODE_FREE16 && ovf_lo[i] && !(wr && (addr == A_LO || addr == A_LO + 12'h001)))
      |=> {count_high_byte[i], count_low_byte[i]} == 16'h0000)
      else $error("Mode 1 did not wrap to zero");
  end

  // ----------------------------------------
  // Overflow flags and control register
  // ----------------------------------------
  // Timer 0 flag unless toggling
  assign t0_set = ovf_lo[0] & ~timer_toggle_status_reg[TG_T0];
  // Split high byte owns t1 flag
  assign t1_set = (t0_split ? ovf_split_hi : ovf_lo[1]) & ~timer_toggle_status_reg[TG_T1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_control_flags <= RST_BYTE;
    end else begin
      // Software owns run and type bits
      if (wr && addr == OFS_CTRL) timer_control_flags <= bus_req.wdata;
      if (t0_vec_ack && !(wr && addr == OFS_CTRL)) timer_control_flags[CB_TF0] <= 1'b0;
      if (t1_vec_ack && !(wr && addr == OFS_CTRL)) timer_control_flags[CB_TF1] <= 1'b0;
      if (x0_vec_ack && !(wr && addr == OFS_CTRL)) timer_control_flags[CB_IE0] <= 1'b0;
      if (x1_vec_ack && !(wr && addr == OFS_CTRL)) timer_control_flags[CB_IE1] <= 1'b0;
      if (t0_set) timer_control_flags[CB_TF0] <= 1'b1;
      if (t1_set) timer_control_flags[CB_TF1] <= 1'b1;
      if (xset[0]) timer_control_flags[CB_IE0] <= 1'b1;
      if (xset[1]) timer_control_flags[CB_IE1] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_mode_select_reg <= RST_BYTE;
      timer_toggle_status_reg <= RST_BYTE;
      presc_r <= RST_BYTE;
      imask_r <= RST_BYTE;
    end else if (wr) begin
      if (addr == OFS_MODE) timer_mode_select_reg <= bus_req.wdata;
      if (addr == OFS_TOGGLE) timer_toggle_status_reg <= bus_req.wdata;
      if (addr == OFS_PRESC) presc_r <= bus_req.wdata;
      if (addr == OFS_IMASK) imask_r <= bus_req.wdata;
    end
  end

  // Sticky status, read clears, set wins
  assign ev = {xset[1], xset[0], t1_set, t0_set};
  always_ff @(posedge core_clk) begin
    if (rst) istat_r <= RST_BYTE;
    else if (rd && addr == OFS_ISTAT) istat_r <= {4'h0, ev};
    else istat_r <= istat_r | {4'h0, ev};
  end

  always_ff @(posedge core_clk) begin
    if (rst) baud_tick <= 1'b0;
    else baud_tick <= ovf_lo[1];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_r <= RST_BYTE;
    end else if (rd) begin
      unique case (addr)
        OFS_CTRL: rd_data_r <= timer_control_flags;
        OFS_MODE: rd_data_r <= timer_mode_select_reg;
        OFS_T0_LO: rd_data_r <= count_low_byte[0];
        OFS_T0_LO + 12'h001: rd_data_r <= count_high_byte[0];
        OFS_T0_LO + 12'h002: rd_data_r <= count_low_byte[1];
        OFS_T0_LO + 12'h003: rd_data_r <= count_high_byte[1];
        OFS_RL0_LO: rd_data_r <= low_reload_holding[0];
        OFS_RL0_LO + 12'h001: rd_data_r <= high_reload_holding[0];
        OFS_RL0_LO + 12'h002: rd_data_r <= low_reload_holding[1];
        OFS_RL0_LO + 12'h003: rd_data_r <= high_reload_holding[1];
        OFS_TOGGLE: rd_data_r <= timer_toggle_status_reg;
        OFS_PRESC: rd_data_r <= presc_r;
        OFS_ISTAT: rd_data_r <= istat_r;
        OFS_IMASK: rd_data_r <= imask_r;
        default: rd_data_r <= RST_BYTE;
      endcase
    end else begin
      rd_data_r <= RST_BYTE;
    end
  end

  assign rd_data = rd_data_r;
  assign irq = |(istat_r & imask_r);
  assign t0_overflow_flag = timer_control_flags[CB_TF0];
  assign t1_overflow_flag = timer_control_flags[CB_TF1];
  assign ext_ext_pin_a_edge_flag = timer_control_flags[CB_IE0];
  assign ext_int1_edge_flag = timer_control_flags[CB_IE1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  t1_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (timer_mode_select_reg[5:4] == MODE_SPLIT && !wr)
    |=> count_low_byte[1] == $past(count_low_byte[1])
        && count_high_byte[1] == $past(count_high_byte[1]))
    else $error("Timer 1 moved in mode 3");
  t1_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    t1_set |=> timer_control_flags[CB_TF1])
    else $error("Timer 1 flag missed");
  t0_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_lo[0] && timer_toggle_status_reg[TG_T0] && !timer_control_flags[CB_TF0]
     && !wr && !t0_split) |=> !timer_control_flags[CB_TF0])
    else $error("Timer 0 flag set while toggling");
  ext_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    (timer_control_flags[CB_IT0] && xprev_r[0] && !pin_s2_r[2])
    |=> timer_control_flags[CB_IE0])
    else $error("Edge flag not set");
  t0_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (!timer_control_flags[CB_TR0] && !wr)
    |=> count_low_byte[0] == $past(count_low_byte[0]))
    else $error("Timer 0 advanced while stopped");
  split_t1_a: assert property (@(posedge core_clk) disable iff (rst)
    (t0_split && ovf_lo[1]) |-> !t1_set ##1 baud_tick)
    else $error("Timer 1 overflow misrouted in split");
  tick_space_a: assert property (@(posedge core_clk) disable iff (rst)
    (prescaled_timer_tick && presc_r[1:0] == 2'h0)
    |-> ##1 (!prescaled_timer_tick || presc_r[1:0] != 2'h0) [*3]
        ##1 (prescaled_timer_tick || presc_r[1:0] != 2'h0))
    else $error("Prescale by four spacing wrong");
  sample_alt_a: assert property (@(posedge core_clk) disable iff (rst)
    cfall[0] |=> !cfall[0])
    else $error("Counter input sampled too often");

endmodule : dtc_timer

// ==== design/dtc_pkg.sv ====
/*
  Constants, types and register map for the dual timer/counter block.
  Assumes one 125 MHz clock that also serves as the oscillator reference.
*/
// Behaviour
// - Mode 0: 16-bit count, reload both bytes
// - Separate high/low reload registers per timer
// - Mode 2 low reload from low holding
// - Mode 2: low byte counts, high unchanged
// - Mode 1: free 16-bit count, no reload
// - Mode 0 period: prescale times 65536-reload
// - Mode 2 period: prescale times 256-reload
// - Timer 1 mode 3 holds count
// - Timer 0 mode 3 low byte independent
// - Timer 0 mode 3 high byte uses t1 controls
// - Timer 1 runs without interrupt meanwhile
// - Timer 1 overflow sets bit 7, clearable
// - Timer 0 overflow sets bit 5, clearable
// - External edge flags set, cleared on service
// - Counter input sampled every two cycles
// - Mode field and select bit per timer
package dtc_pkg;

  localparam int ADDR_W = 12;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h410;
  localparam logic [11:0] OFS_MODE = 12'h411;
  localparam logic [11:0] OFS_T0_LO = 12'h412;
  localparam logic [11:0] OFS_RL0_LO = 12'h416;
  localparam logic [11:0] OFS_TOGGLE = 12'h41a;
  localparam logic [11:0] OFS_PRESC = 12'h41b;
  localparam logic [11:0] OFS_ISTAT = 12'h41c;
  localparam logic [11:0] OFS_IMASK = 12'h41d;
  localparam int OFS_STRIDE = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------
  // Control register bit positions
  // ----------------------------------------
  localparam int CB_TF1 = 7;
  localparam int CB_TR1 = 6;
  localparam int CB_TF0 = 5;
  localparam int CB_TR0 = 4;
  localparam int CB_IE1 = 3;
  localparam int CB_IT1 = 2;
  localparam int CB_IE0 = 1;
  localparam int CB_IT0 = 0;

  localparam int TG_T0 = 0;
  localparam int TG_T1 = 2;
  localparam int MODE_HALF_W = 4;

  localparam int IS_T0 = 0;
  localparam int IS_T1 = 1;
  localparam int IS_X0 = 2;
  localparam int IS_X1 = 3;

  // ----------------------------------------
  // Timing, in oscillator cycles
  // ----------------------------------------
  localparam int PRESC_A = 4;
  localparam int PRESC_B = 16;
  localparam int PRESC_C = 64;
  localparam int SAMPLE_DIV = 2;
  localparam logic [5:0] DIV_LIM_A = 6'(PRESC_A - 1);
  localparam logic [5:0] DIV_LIM_B = 6'(PRESC_B - 1);
  localparam logic [5:0] DIV_LIM_C = 6'(PRESC_C - 1);
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_RELOAD16,
    MODE_FREE16,
    MODE_RELOAD8,
    MODE_SPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic gate;
    logic count_sel;
    logic [1:0] mode;
  } dtc_timer_mode_select_reg_half_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_bus_req_t;

endpackage : dtc_pkg

// ==== dv/dtc_timer_test.sv ====
/*
  Self-checking bench for the dual timer/counter block.
  Assumes the block's register port, pins and acknowledges are driven from here.
*/
`timescale 1ns/1ps
module dtc_timer_test
  import dtc_pkg::*;
;
  // ----------------------------------------
  // Design hookup
  // ----------------------------------------
  logic core_clk;
  logic rst;
  dtc_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic t0_pin;
  logic t1_pin;
  logic pin_a;
  logic pin_b;
  logic [3:0] ack;
  logic tf0, tf1, xf0, xf1, baud_tick, irq;
  logic [3:0] ev;
  int num_errors;
  int total_checks;
  int c;
  logic [7:0] v;

  assign ev = {xf0, baud_tick, tf1, tf0};

  dtc_timer dut_u (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .t0_count_pin(t0_pin), .t1_count_pin(t1_pin), .ext_pin_a(pin_a), .ext_pin_b(pin_b),
    .t0_vec_ack(ack[0]), .t1_vec_ack(ack[1]), .x0_vec_ack(ack[2]), .x1_vec_ack(ack[3]),
    .t0_overflow_flag(tf0), .t1_overflow_flag(tf1), .ext_ext_pin_a_edge_flag(xf0),
    .ext_int1_edge_flag(xf1), .baud_tick(baud_tick), .irq(irq)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask : chk

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rdchk

  // Bounded wait for one event line, cycles waited in c
  task automatic wev(input int k);
    c = 0;
    while (ev[k] !== 1'b1 && c < 3000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    if (ev[k] !== 1'b1) begin
      $display("CHECK FAILED event %0d expected 1 seen 0", k);
      num_errors++;
    end
  endtask : wev

  task automatic pulse(input int k);
    @(posedge core_clk);
    ack[k] <= 1'b1;
    @(posedge core_clk);
    ack[k] <= 1'b0;
    #1;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  // Every setting below gives a 64-cycle overflow period
  task automatic per(input logic [7:0] md, input logic [7:0] ps, input logic [7:0] lo,
      input logic [7:0] hi);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_RL0_LO, lo);
    wr(12'(OFS_RL0_LO + 1), hi);
    wr(OFS_T0_LO, lo);
    wr(12'(OFS_T0_LO + 1), hi);
    wr(OFS_MODE, md);
    wr(OFS_PRESC, ps);
    wr(OFS_CTRL, 8'h10);
    wev(0);
    pulse(0);
    wev(0);
    chk("period", 8'h40, 8'(c + 2));
    wr(OFS_CTRL, 8'h00);
    rdchk(12'(OFS_T0_LO + 1), hi);
    rd(OFS_T0_LO, v);
    idle(20);
    rdchk(OFS_T0_LO, v);
  endtask : per

  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    bus_req = '0;
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    pin_a = 1'b1;
    pin_b = 1'b1;
    ack = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(OFS_CTRL, 8'h00);
    rdchk(OFS_MODE, 8'h00);
    rdchk(12'h400, 8'h00);
    wr(OFS_CTRL, 8'h05);
    rdchk(OFS_CTRL, 8'h05);
    per(8'h00, 8'h00, 8'hf0, 8'hff);
    per(8'h02, 8'h01, 8'hfc, 8'h5a);
    per(8'h02, 8'h02, 8'hff, 8'h5a);
    per(8'h02, 8'h03, 8'hff, 8'h5a);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(OFS_IMASK, 8'h01);
    chk("irq on", 8'h01, {7'h00, irq});
    rdchk(OFS_ISTAT, 8'h01);
    chk("irq cleared", 8'h00, {7'h00, irq});
    // Toggle enable keeps the flag down
    wr(OFS_TOGGLE, 8'h01);
    wr(OFS_CTRL, 8'h10);
    idle(150);
    chk("tf0 suppressed", 8'h00, {7'h00, tf0});
    wr(OFS_TOGGLE, 8'h00);
    // Free count wraps to zero, no reload
    wr(OFS_CTRL, 8'h00);
    wr(OFS_T0_LO, 8'hf0);
    wr(12'(OFS_T0_LO + 1), 8'hff);
    wr(OFS_MODE, 8'h01);
    wr(OFS_PRESC, 8'h00);
    wr(OFS_CTRL, 8'h10);
    wev(0);
    wr(OFS_CTRL, 8'h00);
    rdchk(12'(OFS_T0_LO + 1), 8'h00);
    // Counter mode counts falling pin edges
    wr(OFS_T0_LO, 8'h00);
    wr(OFS_MODE, 8'h05);
    wr(OFS_CTRL, 8'h10);
    repeat (5) begin
      repeat (4) @(posedge core_clk);
      t0_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      t0_pin <= 1'b1;
    end
    idle(12);
    wr(OFS_CTRL, 8'h00);
    rdchk(OFS_T0_LO, 8'h05);
    // Timer 1 in its own split mode holds
    wr(12'(OFS_T0_LO + 2), 8'h33);
    wr(12'(OFS_T0_LO + 3), 8'h44);
    wr(OFS_MODE, 8'h30);
    wr(OFS_CTRL, 8'h40);
    idle(100);
    rdchk(12'(OFS_T0_LO + 2), 8'h33);
    rdchk(12'(OFS_T0_LO + 3), 8'h44);
    // Timer 0 split: timer 1 only feeds the baud tick
    wr(OFS_CTRL, 8'h00);
    wr(12'(OFS_T0_LO + 1), 8'hfc);
    wr(12'(OFS_T0_LO + 2), 8'hf8);
    wr(12'(OFS_T0_LO + 3), 8'hff);
    wr(OFS_MODE, 8'h13);
    wev(2);
    chk("baud tick", 8'h01, {7'h00, c < 200});
    chk("tf1 quiet", 8'h00, {7'h00, tf1});
    wr(OFS_CTRL, 8'h40);
    wev(1);
    chk("tf1 from t0 high", 8'h01, {7'h00, c < 40});
    pulse(1);
    chk("tf1 vectored", 8'h00, {7'h00, tf1});
    // External pin: edge then level triggering
    wr(OFS_CTRL, 8'h01);
    @(posedge core_clk);
    pin_a <= 1'b0;
    idle(8);
    chk("edge flag", 8'h01, {7'h00, xf0});
    pulse(2);
    idle(4);
    chk("edge once", 8'h00, {7'h00, xf0});
    wr(OFS_CTRL, 8'h00);
    pulse(2);
    idle(2);
    chk("level flag", 8'h01, {7'h00, xf0});
    @(posedge core_clk);
    pin_a <= 1'b1;
    idle(6);
    pulse(2);
    chk("level gone", 8'h00, {7'h00, xf0});
    // Second external pin, edge triggered
    wr(OFS_CTRL, 8'h04);
    @(posedge core_clk);
    pin_b <= 1'b0;
    idle(8);
    chk("edge flag 1", 8'h01, {7'h00, xf1});
    pulse(3);
    chk("edge 1 served", 8'h00, {7'h00, xf1});
    give_verdict();
  end
endmodule : dtc_timer_test
